//--- hdl/frequency_sweep_list_sequencer.sv
// sweep and list sequencer: config registers, trigger handling, point stepping, trigger output
`timescale 1ns/10ps
`default_nettype none
// Operation
// [RL1] free-running: a start trigger runs points with hold time for the cycle count
// [RL2] free-running: another trigger while running ends the sweep
// [RL3] software uses step-per-trigger only with hardware trigger source
// [RL4] step-per-trigger: each accepted trigger advances one point
// [RL5] step-per-trigger: stop after the programmed cycles complete
// [RL6] after completion a hardware trigger restarts stepping
// [RL7] software trigger or rf mode fixed tone stops stepping early
// [RL8] item_a clear: hold the last point at sequence end
// [RL9] item_a set: return to the first point after the cycle and stop
// [RL10] trigger output pulses only while trigger_out_enable is set
// [RL11] trigger_out_select clear: pulse after each point is fully applied
// [RL12] trigger_out_select set: pulse at each completed cycle
// [RL13] software keeps start frequency below stop frequency
// [RL14] software keeps stop frequency above start frequency
// [RL15] software keeps step size within stop minus start
// [RL16] first point follows the direction bit, not start/stop order
// [RL17] each point is held for hold register times 500 us; the code holds a zero value for one unit
// [RL18] cycle count zero runs forever, otherwise that many cycles
// [RL19] point source: 0 list memory, 1 computed from start, stop, step
// [RL20] trigger source: 0 software, 1 trigger input pin edge
// [RL21] triggers act only with rf mode set to sweep/list
// [RL22] idle fixed tone ignores triggers; a new start clears index and count
module frequency_sweep_list_sequencer #(
  parameter int HOLD_UNIT_CYCLES = sweep_pkg::HOLD_UNIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // command interface
  input wire sweep_pkg::reg_wr_s reg_wr,
  input wire sweep_pkg::list_wr_s list_wr,
  // triggers
  input wire logic sw_trigger,
  input wire logic trigger_input_pin,
  // point and status
  output logic [sweep_pkg::FREQ_W-1:0] frequency_out,
  output logic [sweep_pkg::IDX_W-1:0] point_index,
  output logic sweep_active,
  output logic trigger_output_pin
);

  localparam logic [sweep_pkg::COUNT_W-1:0] UNIT_LAST = sweep_pkg::COUNT_W'(HOLD_UNIT_CYCLES - 1);
  localparam logic [sweep_pkg::COUNT_W-1:0] DEPTH_C = sweep_pkg::COUNT_W'(sweep_pkg::LIST_DEPTH);

  function automatic logic last_idx_ok(input logic [sweep_pkg::COUNT_W-1:0] n);
    last_idx_ok = (n != sweep_pkg::COUNT_RESET) && (n <= DEPTH_C);
  endfunction

  function automatic logic edge_seen(input logic rise, input logic now, input logic prev);
    edge_seen = rise ? (now & ~prev) : (~now & prev);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  sweep_pkg::mode_cfg_s mode_reg, mode_next;
  logic rf_mode_reg, rf_mode_next;
  logic edge_rise_reg, edge_rise_next;
  logic [sweep_pkg::FREQ_W-1:0] start_reg, start_next, stop_reg, stop_next, step_reg, step_next;
  logic [sweep_pkg::HOLD_W-1:0] hold_reg, hold_next;
  logic [sweep_pkg::COUNT_W-1:0] cycles_reg, cycles_next, points_reg, points_next;

  always_comb begin
    mode_next = mode_reg;
    rf_mode_next = rf_mode_reg;
    edge_rise_next = edge_rise_reg;
    start_next = start_reg;
    stop_next = stop_reg;
    step_next = step_reg;
    hold_next = hold_reg;
    cycles_next = cycles_reg;
    points_next = points_reg;
    if (reg_wr.en) begin
      case (reg_wr.addr)
        sweep_pkg::RF_MODE_ADDR: rf_mode_next = reg_wr.data[sweep_pkg::RF_MODE_BIT];
        sweep_pkg::MODE_CFG_ADDR: mode_next = sweep_pkg::mode_cfg_s'(reg_wr.data[sweep_pkg::MODE_W-1:0]);
        sweep_pkg::START_FREQ_ADDR: start_next = reg_wr.data;
        sweep_pkg::STOP_FREQ_ADDR: stop_next = reg_wr.data;
        sweep_pkg::STEP_SIZE_ADDR: step_next = reg_wr.data;
        sweep_pkg::HOLD_INTERVAL_ADDR: hold_next = reg_wr.data[sweep_pkg::HOLD_W-1:0];
        sweep_pkg::CYCLE_COUNT_ADDR: cycles_next = reg_wr.data[sweep_pkg::COUNT_W-1:0];
        sweep_pkg::HW_TRIGGER_ADDR: edge_rise_next = reg_wr.data[sweep_pkg::HW_EDGE_BIT];
        sweep_pkg::LIST_POINTS_ADDR: points_next = reg_wr.data[sweep_pkg::COUNT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_reg <= sweep_pkg::mode_cfg_s'(sweep_pkg::MODE_CFG_RESET);
      rf_mode_reg <= 1'b0;
      edge_rise_reg <= 1'b0;
      start_reg <= sweep_pkg::FREQ_RESET;
      stop_reg <= sweep_pkg::FREQ_RESET;
      step_reg <= sweep_pkg::FREQ_RESET;
      hold_reg <= sweep_pkg::COUNT_RESET;
      cycles_reg <= sweep_pkg::COUNT_RESET;
      points_reg <= sweep_pkg::COUNT_RESET;
    end else begin
      mode_reg <= mode_next;
      rf_mode_reg <= rf_mode_next;
      edge_rise_reg <= edge_rise_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
      step_reg <= step_next;
      hold_reg <= hold_next;
      cycles_reg <= cycles_next;
      points_reg <= points_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  sweep_pkg::seq_state_e state_reg, state_next;
  logic [sweep_pkg::FREQ_W-1:0] freq_reg, freq_next;
  logic [sweep_pkg::IDX_W-1:0] idx_reg, idx_next, last_idx;
  logic up_reg, up_next, leg_reg, leg_next, pin_prev_reg, pin_prev_next;
  logic [sweep_pkg::COUNT_W-1:0] cyc_reg, cyc_next, unit_reg, unit_next, held_reg, held_next;
  logic hw_edge, start_trig, at_top, at_bot, limit, dwell_done;
  logic chg, cyc_pulse, do_begin, do_adv, do_move, mv_up;

  assign last_idx = last_idx_ok(points_reg) ? sweep_pkg::IDX_W'(points_reg - 1'b1) : sweep_pkg::IDX_RESET;
  // 49-bit compares so the top-of-range test cannot wrap
  assign at_top = mode_reg.point_source_select ? ({1'b0, freq_reg} + {1'b0, step_reg} > {1'b0, stop_reg})
                                               : (idx_reg == last_idx);
  assign at_bot = mode_reg.point_source_select ? ({1'b0, freq_reg} < {1'b0, start_reg} + {1'b0, step_reg})
                                               : (idx_reg == sweep_pkg::IDX_RESET);
  assign limit = up_reg ? at_top : at_bot;

  always_comb begin
    state_next = state_reg;
    freq_next = freq_reg;
    idx_next = idx_reg;
    up_next = up_reg;
    leg_next = leg_reg;
    cyc_next = cyc_reg;
    unit_next = unit_reg;
    held_next = held_reg;
    pin_prev_next = trigger_input_pin;
    chg = 1'b0;
    cyc_pulse = 1'b0;
    do_begin = 1'b0;
    do_adv = 1'b0;
    do_move = 1'b0;
    mv_up = up_reg;
    // [RL20] trigger source select
    hw_edge = edge_seen(edge_rise_reg, trigger_input_pin, pin_prev_reg);
    start_trig = mode_reg.hw_trigger_source ? hw_edge : sw_trigger;
    // [RL17] hold interval in 500 us units; zero acts as one unit
    dwell_done = (unit_reg == UNIT_LAST) && ((held_reg + 1'b1) >= hold_reg);
    if (state_reg == sweep_pkg::ST_RUN) begin
      unit_next = (unit_reg == UNIT_LAST) ? sweep_pkg::COUNT_RESET : unit_reg + 1'b1;
      held_next = (unit_reg == UNIT_LAST) ? held_reg + 1'b1 : held_reg;
    end
    case (state_reg)
      sweep_pkg::ST_IDLE: begin
        // [RL21] triggers need sweep/list rf mode
        if (rf_mode_reg && start_trig) begin
          // [RL22] new start clears count
          do_begin = 1'b1;
          cyc_next = sweep_pkg::COUNT_RESET;
          // [RL6] restart stepping
          state_next = mode_reg.step_per_trigger ? sweep_pkg::ST_STEP : sweep_pkg::ST_RUN;
        end
      end
      sweep_pkg::ST_RUN: begin
        // [RL2] second trigger ends
        if (!rf_mode_reg || start_trig) begin
          state_next = sweep_pkg::ST_IDLE;
        end else if (dwell_done) begin
          // [RL1] self-timed stepping
          do_adv = 1'b1;
        end
      end
      sweep_pkg::ST_STEP: begin
        // [RL7] early stop events
        if (!rf_mode_reg || sw_trigger) begin
          state_next = sweep_pkg::ST_IDLE;
        end else if (hw_edge) begin
          // [RL4] one point per trigger
          do_adv = 1'b1;
        end
      end
      default: state_next = sweep_pkg::ST_IDLE;
    endcase
    if (do_adv) begin
      if (!limit) begin
        do_move = 1'b1;
      end else if (mode_reg.triangular && !leg_reg) begin
        // turn around for the return leg
        leg_next = 1'b1;
        up_next = ~up_reg;
        mv_up = ~up_reg;
        do_move = 1'b1;
      end else begin
        cyc_pulse = 1'b1;
        cyc_next = cyc_reg + 1'b1;
        // [RL18] zero count never ends
        if ((cycles_reg != sweep_pkg::COUNT_RESET) && ((cyc_reg + 1'b1) == cycles_reg)) begin
          // [RL5] stop on completion
          state_next = sweep_pkg::ST_IDLE;
          // [RL9] back to first point; [RL8] otherwise hold last point
          do_begin = mode_reg.item_a;
        end else begin
          do_begin = 1'b1;
        end
      end
    end
    if (do_move) begin
      chg = 1'b1;
      freq_next = mv_up ? freq_reg + step_reg : freq_reg - step_reg;
      idx_next = mv_up ? idx_reg + 1'b1 : idx_reg - 1'b1;
    end
    if (do_begin) begin
      // [RL16] first point from direction bit
      chg = 1'b1;
      up_next = ~mode_reg.reverse;
      leg_next = 1'b0;
      freq_next = mode_reg.reverse ? stop_reg : start_reg;
      // [RL22] index restarts
      idx_next = mode_reg.reverse ? last_idx : sweep_pkg::IDX_RESET;
    end
    if (chg) begin
      unit_next = sweep_pkg::COUNT_RESET;
      held_next = sweep_pkg::COUNT_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= sweep_pkg::ST_IDLE;
      freq_reg <= sweep_pkg::FREQ_RESET;
      idx_reg <= sweep_pkg::IDX_RESET;
      up_reg <= 1'b1;
      leg_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      cyc_reg <= sweep_pkg::COUNT_RESET;
      unit_reg <= sweep_pkg::COUNT_RESET;
      held_reg <= sweep_pkg::COUNT_RESET;
    end else begin
      state_reg <= state_next;
      freq_reg <= freq_next;
      idx_reg <= idx_next;
      up_reg <= up_next;
      leg_reg <= leg_next;
      pin_prev_reg <= pin_prev_next;
      cyc_reg <= cyc_next;
      unit_reg <= unit_next;
      held_reg <= held_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // point output and trigger output
  logic [sweep_pkg::FREQ_W-1:0] list_freq, freq_out_next;
  logic [sweep_pkg::CHG_PIPE_LEN-1:0] chg_pipe_reg, chg_pipe_next, cyc_pipe_reg, cyc_pipe_next;
  logic trig_next, active_next;

  point_memory u_points (
    .mclk(mclk),
    .srst(srst),
    .wr(list_wr),
    .rd_addr(idx_reg),
    .rd_data(list_freq)
  );

  always_comb begin
    // [RL19] point source select
    freq_out_next = mode_reg.point_source_select ? freq_reg : list_freq;
    // the delay lets the list read and output register settle before the pulse
    chg_pipe_next = {chg_pipe_reg[sweep_pkg::CHG_PIPE_LEN-2:0], chg};
    cyc_pipe_next = {cyc_pipe_reg[sweep_pkg::CHG_PIPE_LEN-2:0], cyc_pulse};
    // [RL10] output gate; [RL11] per point; [RL12] per cycle
    trig_next = mode_reg.trigger_out_enable & (mode_reg.trig_out_select ? cyc_pipe_reg[sweep_pkg::CHG_PIPE_LEN-1]
                                                                        : chg_pipe_reg[sweep_pkg::CHG_PIPE_LEN-1]);
    active_next = (state_next != sweep_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      frequency_out <= sweep_pkg::FREQ_RESET;
      chg_pipe_reg <= '0;
      cyc_pipe_reg <= '0;
      trigger_output_pin <= 1'b0;
      sweep_active <= 1'b0;
      point_index <= sweep_pkg::IDX_RESET;
    end else begin
      frequency_out <= freq_out_next;
      chg_pipe_reg <= chg_pipe_next;
      cyc_pipe_reg <= cyc_pipe_next;
      trigger_output_pin <= trig_next;
      sweep_active <= active_next;
      point_index <= idx_reg;
    end
  end

endmodule
`default_nettype wire

//--- pkg/sweep_pkg.sv
// constants, register map and carrier types for the frequency sweep and list sequencer
`default_nettype none
package sweep_pkg;

  // clock and hold-time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_UNIT_US = 500;
  localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_US * 1000 / CLK_PERIOD_NS;

  // widths and depths
  localparam int FREQ_W = 48;
  localparam int HOLD_W = 32;
  localparam int COUNT_W = 32;
  localparam int ADDR_W = 8;
  localparam int MODE_W = 8;
  localparam int LIST_DEPTH = 2048;
  localparam int IDX_W = 11;

  // register offsets on the command interface
  localparam logic [ADDR_W-1:0] RF_MODE_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] MODE_CFG_ADDR = 8'h05;
  localparam logic [ADDR_W-1:0] START_FREQ_ADDR = 8'h06;
  localparam logic [ADDR_W-1:0] STOP_FREQ_ADDR = 8'h07;
  localparam logic [ADDR_W-1:0] STEP_SIZE_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] HOLD_INTERVAL_ADDR = 8'h09;
  localparam logic [ADDR_W-1:0] CYCLE_COUNT_ADDR = 8'h0A;
  localparam logic [ADDR_W-1:0] HW_TRIGGER_ADDR = 8'h0B;
  localparam logic [ADDR_W-1:0] LIST_POINTS_ADDR = 8'h0C;

  // field positions
  localparam int RF_MODE_BIT = 0;
  localparam int HW_EDGE_BIT = 0;

  // reset values
  localparam logic [MODE_W-1:0] MODE_CFG_RESET = 8'h00;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 48'h0000_0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_RESET = 11'h000;

  // cycles from a point change until its trigger output pulse
  localparam int CHG_PIPE_LEN = 3;

  // mode configuration byte, bit 7 first
  typedef struct packed {
    logic trig_out_select;
    logic trigger_out_enable;
    logic item_a;
    logic step_per_trigger;
    logic hw_trigger_source;
    logic triangular;
    logic reverse;
    logic point_source_select;
  } mode_cfg_s;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [FREQ_W-1:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] addr;
    logic [FREQ_W-1:0] data;
  } list_wr_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_STEP = 2'b10
  } seq_state_e;

endpackage
`default_nettype wire

//--- hdl/point_memory.sv
// list point memory with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module point_memory (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // write side
  input wire sweep_pkg::list_wr_s wr,
  // read side
  input wire logic [sweep_pkg::IDX_W-1:0] rd_addr,
  output logic [sweep_pkg::FREQ_W-1:0] rd_data
);

  logic [sweep_pkg::FREQ_W-1:0] mem [sweep_pkg::LIST_DEPTH];

  always_ff @(posedge mclk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data <= sweep_pkg::FREQ_RESET;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

//--- bench/sweep_monitor.sv
// assertion checker for the sweep sequencer ports
`timescale 1ns/10ps
`default_nettype none
module sweep_monitor #(
  parameter int HOLD_UNIT_CYCLES = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // inputs
  input wire sweep_pkg::reg_wr_s reg_wr,
  input wire sweep_pkg::list_wr_s list_wr,
  input wire logic sw_trigger,
  input wire logic trigger_input_pin,
  // outputs
  input wire logic [sweep_pkg::FREQ_W-1:0] frequency_out,
  input wire logic [sweep_pkg::IDX_W-1:0] point_index,
  input wire logic sweep_active,
  input wire logic trigger_output_pin
);
  sweep_pkg::mode_cfg_s mode_reg;
  sweep_pkg::mode_cfg_s mode_next;
  logic rf_reg;
  logic rf_next;
  logic pin_reg;
  logic [2:0] off_reg;
  logic [2:0] off_next;
  logic [2:0] quiet_reg;
  logic [2:0] quiet_next;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////
  // shadow config; counters saturate at 7 so they stay tiny
  always_comb begin
    mode_next = mode_reg;
    rf_next = rf_reg;
    if (reg_wr.en && reg_wr.addr == sweep_pkg::MODE_CFG_ADDR) begin
      mode_next = sweep_pkg::mode_cfg_s'(reg_wr.data[7:0]);
    end
    if (reg_wr.en && reg_wr.addr == sweep_pkg::RF_MODE_ADDR) begin
      rf_next = reg_wr.data[0];
    end
    off_next = mode_reg.trigger_out_enable ? 3'h0 : (off_reg == 3'h7 ? 3'h7 : off_reg + 3'h1);
    quiet_next = (sw_trigger || reg_wr.en || trigger_input_pin != pin_reg) ? 3'h0
               : (quiet_reg == 3'h7 ? 3'h7 : quiet_reg + 3'h1);
  end
  always_ff @(posedge mclk) begin
    pin_reg <= trigger_input_pin;
    if (srst) begin
      mode_reg <= '0;
      rf_reg <= 1'b0;
      off_reg <= 3'h0;
      quiet_reg <= 3'h0;
    end else begin
      mode_reg <= mode_next;
      rf_reg <= rf_next;
      off_reg <= off_next;
      quiet_reg <= quiet_next;
    end
  end
  //////////////////////////////////////////////////////////////
  sequence s_stops;
    ##[1:2] !sweep_active;
  endsequence
  sequence s_held;
    $stable(frequency_out) [*3];
  endsequence
  property p_reset_zero;
    $fell(srst) |-> frequency_out == '0 && point_index == '0 && !sweep_active && !trigger_output_pin;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not cleared by reset");
  property p_pulse_width;
    trigger_output_pin |=> !trigger_output_pin;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("trigger pulse too long");
  property p_out_off;
    off_reg == 3'h7 |-> !trigger_output_pin;
  endproperty
  a_out_off: assert property (p_out_off) else $error("pulse while output disabled");
  property p_rf_off;
    !rf_reg |-> s_stops;
  endproperty
  a_rf_off: assert property (p_rf_off) else $error("active in fixed tone mode");
  property p_sw_stop;
    sweep_active && rf_reg && sw_trigger && (mode_reg.step_per_trigger || !mode_reg.hw_trigger_source)
      |-> s_stops;
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("software trigger did not stop");
  property p_step_quiet;
    mode_reg.step_per_trigger && quiet_reg == 3'h7 |-> $stable(frequency_out);
  endproperty
  a_step_quiet: assert property (p_step_quiet) else $error("point moved with no trigger");
  property p_hold_min;
    HOLD_UNIT_CYCLES >= 4 && $changed(frequency_out) && sweep_active && !mode_reg.step_per_trigger
      |=> s_held;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("point held too briefly");
  property p_change_pulse;
    $changed(frequency_out) && sweep_active && mode_reg.trigger_out_enable && !mode_reg.trig_out_select
      && !mode_reg.point_source_select |=> trigger_output_pin;
  endproperty
  a_change_pulse: assert property (p_change_pulse) else $error("no pulse after list change");
  // computed points skip the list read, so they reach the output a cycle before the pulse pipe ends
  property p_change_pulse_cmp;
    $changed(frequency_out) && sweep_active && mode_reg.trigger_out_enable && !mode_reg.trig_out_select
      && mode_reg.point_source_select |=> ##1 trigger_output_pin;
  endproperty
  a_change_pulse_cmp: assert property (p_change_pulse_cmp) else $error("no pulse after sweep change");
endmodule
bind frequency_sweep_list_sequencer sweep_monitor #(
  .HOLD_UNIT_CYCLES(HOLD_UNIT_CYCLES)
) u_monitor (
  .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .list_wr(list_wr),
  .sw_trigger(sw_trigger), .trigger_input_pin(trigger_input_pin),
  .frequency_out(frequency_out), .point_index(point_index),
  .sweep_active(sweep_active), .trigger_output_pin(trigger_output_pin)
);
`default_nettype wire

//--- bench/frequency_sweep_list_sequencer_tb_top.sv
// self-checking bench for the sweep and list sequencer
`timescale 1ns/10ps
`default_nettype none
module frequency_sweep_list_sequencer_tb_top;
  logic mclk;
  logic srst;
  sweep_pkg::reg_wr_s reg_wr;
  sweep_pkg::list_wr_s list_wr;
  logic sw_trigger;
  logic trigger_input_pin;
  logic [47:0] frequency_out;
  logic [10:0] point_index;
  logic sweep_active;
  logic trigger_output_pin;
  int num_errors;
  int checks_done;
  int pulses = 0;
  // short hold unit keeps the run brief
  frequency_sweep_list_sequencer #(
    .HOLD_UNIT_CYCLES(4)
  ) dut (
    .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .list_wr(list_wr),
    .sw_trigger(sw_trigger), .trigger_input_pin(trigger_input_pin),
    .frequency_out(frequency_out), .point_index(point_index),
    .sweep_active(sweep_active), .trigger_output_pin(trigger_output_pin)
  );
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (trigger_output_pin === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    num_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic cmp_val(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail($sformatf("value %h exp %h", got, exp));
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail($sformatf("flag %b exp %b", got, exp));
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      fail($sformatf("pulses %0d exp %0d", got, exp));
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // the gap cycle keeps each strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [47:0] d);
    reg_wr = {1'b1, a, d};
    tick(1);
    reg_wr.en = 1'b0;
    tick(1);
  endtask
  task automatic sw_pulse;
    sw_trigger = 1'b1;
    tick(1);
    sw_trigger = 1'b0;
    tick(1);
  endtask
  task automatic hw_edge;
    trigger_input_pin = 1'b1;
    tick(2);
    trigger_input_pin = 1'b0;
    tick(1);
  endtask
  task automatic wait_idle(input int lim);
    int i;
    i = 0;
    while (sweep_active !== 1'b0 && i < lim) begin
      tick(1);
      i++;
    end
    if (i >= lim) begin
      fail("sequence never stopped");
      print_verdict();
    end
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_ignore;
    int p0;
    p0 = pulses;
    cmp_val(frequency_out, 48'h0);
    wr(8'h05, 48'h41);
    sw_pulse();
    tick(4);
    cmp_bit(sweep_active, 1'b0);
    cmp_cnt(pulses - p0, 0);
  endtask
  task automatic t_step;
    int p0;
    wr(8'h06, 48'h64);
    wr(8'h07, 48'h78);
    wr(8'h08, 48'ha);
    wr(8'h0a, 48'h1);
    // step-per-trigger only ever goes with the hardware source
    wr(8'h05, 48'h59);
    wr(8'h04, 48'h1);
    p0 = pulses;
    for (int k = 0; k < 3; k++) begin
      hw_edge();
      tick(6);
      cmp_val(frequency_out, 48'(100 + 10 * k));
    end
    hw_edge();
    tick(6);
    cmp_bit(sweep_active, 1'b0);
    cmp_val(frequency_out, 48'h78);
    cmp_cnt(pulses - p0, 3);
    hw_edge();
    tick(6);
    cmp_bit(sweep_active, 1'b1);
    cmp_val(frequency_out, 48'h64);
    sw_pulse();
    tick(3);
    cmp_bit(sweep_active, 1'b0);
  endtask
  task automatic t_free;
    int p0;
    wr(8'h09, 48'h2);
    // sawtooth in reverse, so the first point differs from the last
    wr(8'h05, 48'he3);
    p0 = pulses;
    sw_pulse();
    tick(2);
    cmp_val(frequency_out, 48'h78);
    cmp_bit(sweep_active, 1'b1);
    tick(4);
    cmp_val(frequency_out, 48'h78);
    tick(2);
    cmp_val(frequency_out, 48'h6e);
    wait_idle(100);
    tick(6);
    cmp_val(frequency_out, 48'h78);
    cmp_cnt(pulses - p0, 1);
  endtask
  task automatic t_stop;
    int p0;
    wr(8'h0a, 48'h0);
    wr(8'h05, 48'h1);
    p0 = pulses;
    sw_pulse();
    tick(60);
    cmp_bit(sweep_active, 1'b1);
    sw_pulse();
    tick(3);
    cmp_bit(sweep_active, 1'b0);
    cmp_cnt(pulses - p0, 0);
  endtask
  task automatic t_list;
    for (int i = 0; i < 3; i++) begin
      list_wr = {1'b1, 11'(i), 48'(4096 * (i + 1))};
      tick(1);
    end
    list_wr.en = 1'b0;
    wr(8'h0c, 48'h3);
    wr(8'h05, 48'h18);
    hw_edge();
    tick(6);
    cmp_val(frequency_out, 48'h1000);
    hw_edge();
    tick(6);
    cmp_val(frequency_out, 48'h2000);
    cmp_val(48'(point_index), 48'h1);
    wr(8'h04, 48'h0);
    tick(3);
    cmp_bit(sweep_active, 1'b0);
    // rising edge select: the rise starts at once, the fall must not step
    wr(8'h0b, 48'h1);
    wr(8'h04, 48'h1);
    trigger_input_pin = 1'b1;
    tick(1);
    cmp_bit(sweep_active, 1'b1);
    tick(6);
    cmp_val(frequency_out, 48'h1000);
    trigger_input_pin = 1'b0;
    tick(6);
    cmp_val(frequency_out, 48'h1000);
    sw_pulse();
    tick(3);
    cmp_bit(sweep_active, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    reg_wr = '0;
    list_wr = '0;
    sw_trigger = 1'b0;
    trigger_input_pin = 1'b0;
    num_errors = 0;
    checks_done = 0;
    tick(6);
    srst = 1'b0;
    tick(1);
    t_ignore();
    t_step();
    t_free();
    t_stop();
    t_list();
    print_verdict();
  end
endmodule
`default_nettype wire
